// ===== verilog/debug_port_regs.svh
// Purpose: Offsets, field positions, reset values for the debug port control block
// Assumes: APB byte addressing, one 32-bit word per register
// Notes:   Definitions only
`ifndef DEBUG_PORT_REGS_SVH
`define DEBUG_PORT_REGS_SVH

// ==================================================================
// Offsets
`define DPC_CONTROL_OFFSET   12'h000
`define DPC_STATUS_OFFSET    12'h004

// ==================================================================
// Field positions
`define DPC_USB_BIT          7
`define DPC_UART_A_BIT       6
`define DPC_UART_B_BIT       5
`define DPC_SPI_A_BIT        4
`define DPC_TEST_BIT         3
`define DPC_TRACE_BIT        2

// ==================================================================
// Reset values
`define DPC_CONTROL_RESET    32'h0000_000B
`define DPC_FIELD_MASK       32'h0000_00FC
`define DPC_RSVD_LOW_READ    32'h0000_0003

`endif

// ===== verilog/debug_port_pkg.sv
// Purpose: Types shared by the debug port control block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Offsets live in the _regs header
package debug_port_pkg;

    // ==================================================================
    // Register selection
    typedef enum logic [1:0] {
        sel_none    = 2'b00,
        sel_control = 2'b01,
        sel_status  = 2'b10
    } reg_sel_e;

    typedef logic [31:0] word_t;

endpackage

// ===== verilog/input_sync.sv
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Single clock pclk, clock enable freezes state
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else if (clk_en) begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// ===== verilog/apb_decode.sv
// Purpose: APB address decode for the debug port control block
// Assumes: Word aligned offsets, 12-bit address window
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "debug_port_regs.svh"
module apb_decode
    import debug_port_pkg::*;
(
    // Address
    input  wire logic [11:0] paddr,
    // Selection
    output reg_sel_e         sel,
    output logic             slverr
);

    always_comb begin
        sel    = sel_none;
        slverr = 1'b0;
        unique case (paddr)
            `DPC_CONTROL_OFFSET: sel = sel_control;
            `DPC_STATUS_OFFSET:  sel = sel_status;
            default: begin
                sel    = sel_none;
                slverr = 1'b1;
            end
        endcase
    end

endmodule

// ===== verilog/debug_port_control.sv
// Purpose: Debug port control register behind an APB slave
// Assumes: 20 MHz pclk, async active-low reset, clk_en freezes state
// Notes:   Zero wait states; unmapped addresses answer with pslverr
//
// Operation
// [R1] Usb override bit 7 set makes usb ignore its debug freeze.
// [R2] Uart a override bit 6 set makes uart a ignore its freeze.
// [R3] Uart b override bit 5 set makes uart b ignore its freeze.
// [R4] Spi a override bit 4 set makes spi a ignore its freeze.
// [R5] Bit 3 enables test port, resets to one; other fields reset zero.
// [R6] Bit 2 enables the trace output port.
// [R7] Software writes zero to bits 31..8 and ignores them on read.
// [R8] Software writes one to bits 1..0 and ignores them on read.
`timescale 1ns/1ps
`include "debug_port_regs.svh"
module debug_port_control
    import debug_port_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral freeze requests from pins
    input  wire logic        usb_debug_freeze,
    input  wire logic        uart_a_debug_freeze,
    input  wire logic        uart_b_debug_freeze,
    input  wire logic        spi_a_debug_freeze,
    // Effective freeze to peripherals
    output logic             usb_frozen,
    output logic             uart_a_frozen,
    output logic             uart_b_frozen,
    output logic             spi_a_frozen,
    // Debug port enables
    output logic             test_port_enable,
    output logic             trace_port_enable
);

    // ==================================================================
    // Decode and sync
    reg_sel_e   sel;
    logic       dec_err;
    logic [3:0] freeze_sync;
    word_t      control;
    word_t      next_prdata;
    logic       access;
    logic       wr_ctrl;

    apb_decode u_decode (
        .paddr  (paddr),
        .sel    (sel),
        .slverr (dec_err)
    );

    // Freeze requests come from other domains
    input_sync #(.WIDTH(4)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in ({usb_debug_freeze, uart_a_debug_freeze,
                    uart_b_debug_freeze, spi_a_debug_freeze}),
        .sync_out (freeze_sync)
    );

    assign access  = psel && !penable;
    assign wr_ctrl = psel && penable && pwrite && (sel == sel_control);

    // ==================================================================
    // Shared decode
    // Override wins over the peripheral's own freeze request
    function automatic logic gated_freeze(input logic request, input logic override);
        return request && !override;
    endfunction

    // ==================================================================
    // Control register
    // Only fields 7..2 are stored; reserved bits cannot be set by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `DPC_CONTROL_RESET & `DPC_FIELD_MASK; // [R5]
        end else if (clk_en && wr_ctrl) begin
            control <= pwdata & `DPC_FIELD_MASK; // [R7] [R8]
        end
    end

    // ==================================================================
    // Outputs to peripherals, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_frozen        <= 1'b0;
            uart_a_frozen     <= 1'b0;
            uart_b_frozen     <= 1'b0;
            spi_a_frozen      <= 1'b0;
            test_port_enable  <= 1'b1;
            trace_port_enable <= 1'b0;
        end else if (clk_en) begin
            usb_frozen        <= gated_freeze(freeze_sync[3], control[`DPC_USB_BIT]); // [R1]
            uart_a_frozen     <= gated_freeze(freeze_sync[2], control[`DPC_UART_A_BIT]); // [R2]
            uart_b_frozen     <= gated_freeze(freeze_sync[1], control[`DPC_UART_B_BIT]); // [R3]
            spi_a_frozen      <= gated_freeze(freeze_sync[0], control[`DPC_SPI_A_BIT]); // [R4]
            test_port_enable  <= control[`DPC_TEST_BIT]; // [R5]
            trace_port_enable <= control[`DPC_TRACE_BIT]; // [R6]
        end
    end

    // ==================================================================
    // APB answer: pready and data prepared in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (sel)
            sel_control: next_prdata = control | `DPC_RSVD_LOW_READ; // [R8]
            sel_status:  next_prdata = {28'h000_0000, freeze_sync};
            sel_none:    next_prdata = 32'h0000_0000;
            default:     next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= access;
            pslverr <= access && dec_err;
            if (access && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ctrl_write_s;
        clk_en && wr_ctrl;
    endsequence

    // Store edge, then the output edge, then the edge that sees it
    sequence settle_s;
        clk_en [*3];
    endsequence

    sequence setup_any_s;
        clk_en && psel && !penable;
    endsequence

    sequence setup_read_s;
        clk_en && psel && !penable && !pwrite;
    endsequence

    sequence hold_s;
        !clk_en;
    endsequence

    usb_override_a: assert property (clk_en && control[`DPC_USB_BIT] |=> !usb_frozen) // [R1]
        else $error("usb frozen despite override");
    uart_a_override_a: assert property (clk_en && control[`DPC_UART_A_BIT]
        |=> !uart_a_frozen) // [R2]
        else $error("uart a frozen despite override");
    uart_b_follow_a: assert property (clk_en && !control[`DPC_UART_B_BIT]
        |=> uart_b_frozen == $past(freeze_sync[1])) // [R3]
        else $error("uart b does not follow freeze");
    spi_follow_a: assert property (clk_en && !control[`DPC_SPI_A_BIT]
        |=> spi_a_frozen == $past(freeze_sync[0])) // [R4]
        else $error("spi a does not follow freeze");
    test_port_a: assert property (ctrl_write_s ##0 settle_s
        |-> test_port_enable == $past(pwdata[`DPC_TEST_BIT], 2)) // [R5]
        else $error("test port enable wrong after write");
    trace_port_a: assert property (ctrl_write_s ##0 settle_s
        |-> trace_port_enable == $past(pwdata[`DPC_TRACE_BIT], 2)) // [R6]
        else $error("trace enable wrong after write");
    upper_read_a: assert property (psel && !penable && !pwrite && clk_en
        |=> prdata[31:8] == 24'h00_0000) // [R7]
        else $error("upper reserved bits read nonzero");
    low_read_a: assert property (psel && !penable && !pwrite && clk_en
        && sel == sel_control |=> prdata[1:0] == 2'h3) // [R8]
        else $error("low reserved bits read wrong");

    // ==================================================================
    // Freeze paths, the other half of each rule
    property usb_follow_p;
        clk_en && !control[`DPC_USB_BIT] |=> usb_frozen == $past(freeze_sync[3]);
    endproperty
    usb_follow_a: assert property (usb_follow_p) // [R1]
        else $error("usb does not follow freeze");

    property uart_a_follow_p;
        clk_en && !control[`DPC_UART_A_BIT] |=> uart_a_frozen == $past(freeze_sync[2]);
    endproperty
    uart_a_follow_a: assert property (uart_a_follow_p) // [R2]
        else $error("uart a does not follow freeze");

    property uart_b_override_p;
        clk_en && control[`DPC_UART_B_BIT] |=> !uart_b_frozen;
    endproperty
    uart_b_override_a: assert property (uart_b_override_p) // [R3]
        else $error("uart b frozen despite override");

    property spi_override_p;
        clk_en && control[`DPC_SPI_A_BIT] |=> !spi_a_frozen;
    endproperty
    spi_override_a: assert property (spi_override_p) // [R4]
        else $error("spi a frozen despite override");

    // ==================================================================
    // Register storage
    property write_lands_p;
        ctrl_write_s |=> control[7:2] == $past(pwdata[7:2]);
    endproperty
    write_lands_a: assert property (write_lands_p) // [R5] [R6]
        else $error("control write not stored");

    property control_keep_p;
        !(clk_en && wr_ctrl) |=> $stable(control);
    endproperty
    control_keep_a: assert property (control_keep_p)
        else $error("control changed without write");

    // Reserved bits are never stored, whatever software writes
    property reserved_store_p;
        control[31:8] == 24'h00_0000 && control[1:0] == 2'b00;
    endproperty
    reserved_store_a: assert property (reserved_store_p) // [R7] [R8]
        else $error("reserved bits stored");

    // ==================================================================
    // Bus answer
    property pready_answer_p;
        setup_any_s |=> pready;
    endproperty
    pready_answer_a: assert property (pready_answer_p)
        else $error("no ready after setup");

    property pready_idle_p;
        clk_en && !(psel && !penable) |=> !pready;
    endproperty
    pready_idle_a: assert property (pready_idle_p)
        else $error("ready without setup");

    property slverr_bad_p;
        setup_any_s ##0 dec_err |=> pslverr && pready;
    endproperty
    slverr_bad_a: assert property (slverr_bad_p)
        else $error("unmapped access without error");

    property slverr_good_p;
        setup_any_s ##0 !dec_err |=> !pslverr;
    endproperty
    slverr_good_a: assert property (slverr_good_p)
        else $error("error on mapped access");

    property read_fields_p;
        setup_read_s ##0 sel == sel_control |=> prdata[7:2] == $past(control[7:2]);
    endproperty
    read_fields_a: assert property (read_fields_p) // [R5] [R6]
        else $error("control fields read wrong");

    property status_read_p;
        setup_read_s ##0 sel == sel_status |=> prdata == {28'h000_0000, $past(freeze_sync)};
    endproperty
    status_read_a: assert property (status_read_p)
        else $error("status read wrong");

    property unmapped_read_p;
        setup_read_s ##0 sel == sel_none |=> prdata == 32'h0000_0000;
    endproperty
    unmapped_read_a: assert property (unmapped_read_p)
        else $error("unmapped read not zero");

    property prdata_hold_p;
        clk_en && !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    prdata_hold_a: assert property (prdata_hold_p)
        else $error("read data changed without read");

    // ==================================================================
    // Clock enable freezes everything
    property outputs_hold_p;
        hold_s |=> $stable({usb_frozen, uart_a_frozen, uart_b_frozen, spi_a_frozen,
                            test_port_enable, trace_port_enable});
    endproperty
    outputs_hold_a: assert property (outputs_hold_p)
        else $error("outputs moved while disabled");

    property answer_hold_p;
        hold_s |=> $stable(pready) && $stable(pslverr) && $stable(prdata);
    endproperty
    answer_hold_a: assert property (answer_hold_p)
        else $error("bus answer moved while disabled");

endmodule

// ===== tb/freeze_source.sv
// Purpose: Peripheral freeze requests seen by the block
// Assumes: Levels change just after a pclk edge
// Notes:   Pattern chosen by the bench, bit 3 is usb
`timescale 1ns/1ps
module freeze_source (
    // Control
    input  wire logic       pclk,
    input  wire logic [3:0] pattern,
    // Freeze request levels
    output logic            usb_debug_freeze = 1'b0,
    output logic            uart_a_debug_freeze = 1'b0,
    output logic            uart_b_debug_freeze = 1'b0,
    output logic            spi_a_debug_freeze = 1'b0
);
    // ==========================================
    // Requests, held as levels like real freeze bits
    always @(posedge pclk) begin
        {usb_debug_freeze, uart_a_debug_freeze} <= pattern[3:2];
        {uart_b_debug_freeze, spi_a_debug_freeze} <= pattern[1:0];
    end
endmodule

// ===== tb/debug_port_control_test.sv
// Purpose: Self-checking bench for the debug port control block
// Assumes: Zero wait state APB slave, clk_en held high except during the low clock enable hold check
// Notes:   Reads are checked from a queue by a monitor
`timescale 1ns/1ps
module debug_port_control_test
    import debug_port_pkg::*;
;
    // ==========================================
    // Signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [11:0] paddr = 12'h000;
    word_t       pwdata = 32'h0, prdata, v;
    logic        pready, pslverr, test_port_enable, trace_port_enable;
    logic [3:0]  pattern = 4'hF;
    logic        clk_en = 1'b1;
    logic        usb_q, uart_a_q, uart_b_q, spi_a_q, usb_f, uart_a_f, uart_b_f, spi_a_f;
    int          errors = 0, n_compared = 0, seed = 32'h5162;
    word_t       exp_q[$];

    always #25 pclk = ~pclk;

    freeze_source u_src (.pclk(pclk), .pattern(pattern), .usb_debug_freeze(usb_q),
        .uart_a_debug_freeze(uart_a_q), .uart_b_debug_freeze(uart_b_q),
        .spi_a_debug_freeze(spi_a_q));

    debug_port_control u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_debug_freeze(usb_q),
        .uart_a_debug_freeze(uart_a_q), .uart_b_debug_freeze(uart_b_q),
        .spi_a_debug_freeze(spi_a_q), .usb_frozen(usb_f), .uart_a_frozen(uart_a_f),
        .uart_b_frozen(uart_b_f), .spi_a_frozen(spi_a_f),
        .test_port_enable(test_port_enable), .trace_port_enable(trace_port_enable));

    // ==========================================
    // Reporting
    task conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task check(input string name, input word_t exp, input word_t got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ==========================================
    // APB master, one idle edge between transfers
    task apb(input logic wr, input logic [11:0] a, input word_t d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            conclude();
        end
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // ==========================================
    // Read monitor
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) check("stray read", 32'h0, 32'h1);
            else check("prdata", exp_q.pop_front(), prdata);
        end
    end

    // ==========================================
    // Sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("enables", 32'h2, {30'h0, test_port_enable, trace_port_enable});
        exp_q.push_back(32'h0000_000B);
        apb(1'b0, 12'h000, 32'h0);
        for (int i = 0; i < 12; i++) begin
            // Upper bits zero, low two bits one, as software must
            v = (i < 2) ? (i ? 32'h3 : 32'hFF) : (($random(seed) & 32'hFC) | 32'h3);
            pattern <= $random(seed);
            apb(1'b1, 12'h000, v);
            exp_q.push_back(v);
            apb(1'b0, 12'h000, 32'h0);
            repeat (4) @(posedge pclk);
            check("frozen", {28'h0, pattern & ~v[7:4]}, {28'h0, usb_f, uart_a_f, uart_b_f, spi_a_f});
            check("enables", {30'h0, v[3:2]}, {30'h0, test_port_enable, trace_port_enable});
        end
        // Status shows synced requests; a write there must not touch control
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        check("pslverr", 32'h0, {31'h0, slv});
        exp_q.push_back({28'h0, pattern});
        apb(1'b0, 12'h004, 32'h0);
        check("pslverr", 32'h0, {31'h0, slv});
        exp_q.push_back((v & 32'hFC) | 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        // Low clock enable holds every freeze output although requests move
        clk_en <= 1'b0;
        pattern <= ~pattern;
        repeat (6) @(posedge pclk);
        check("held", {28'h0, ~pattern & ~v[7:4]}, {28'h0, usb_f, uart_a_f, uart_b_f, spi_a_f});
        clk_en <= 1'b1;
        repeat (4) @(posedge pclk);
        check("resumed", {28'h0, pattern & ~v[7:4]}, {28'h0, usb_f, uart_a_f, uart_b_f, spi_a_f});
        // Unmapped place answers with an error and zero data
        exp_q.push_back(32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check("pslverr", 32'h1, {31'h0, slv});
        conclude();
    end
endmodule
